// ===== lcd_link_params.svh
`ifndef LCD_LINK_PARAMS_SVH
`define LCD_LINK_PARAMS_SVH
`define SLAVE_ID         7'h3A
`define BLANK_CHAR       8'h20
`define LINE2_ADDR       7'h40
`define RAM_WORDS        128
`define GLYPH_WORDS      64
`define CMD_CLEAR        8'h01
`define CMD_HOME         8'h02
`define CTL_CONT_BIT     7
`define CTL_RS_BIT       6
`define CTL_RW_BIT       5
`define SCL_HALF_DIV     10'd49
`define FIFO_DEPTH       4
`endif

// ===== lcd_link_pkg.sv
package lcd_link_pkg;
  typedef enum logic [1:0] {ENT_INC_NOSHIFT, ENT_INC_SHIFT, ENT_DEC_NOSHIFT, ENT_DEC_SHIFT} entry_mode_t;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_CTRL, SL_WDATA, SL_RDATA, SL_RACK, SL_SKIP} slave_state_t;
  typedef enum logic [3:0] {MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP1, MS_STOP2, MS_DONE} master_state_t;
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rd;
    logic       ack_last;
    logic [7:0] data;
  } host_cmd_t;
endpackage

// ===== lcd_link_if.sv
`timescale 1ns/1ns
interface lcd_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic sda;
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
  modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
  modport slave  (input scl, output sda_s_out, output sda_s_oe, input sda);
endinterface

// ===== lcd_fifo.sv
`timescale 1ns/1ns
module lcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== lcd_host_end.sv
`timescale 1ns/1ns
`include "lcd_link_params.svh"
module lcd_host_end (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // Command stream
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire lcd_link_pkg::host_cmd_t cmd,
  // Read results and status
  output logic                         rd_valid,
  output logic [7:0]                   rd_data,
  output logic                         nack_seen,
  output logic                         busy,
  // Link
  lcd_link_if.master                   link
);
  import lcd_link_pkg::*;
  logic          q_valid;
  logic          q_ready;
  host_cmd_t     q_cmd;
  master_state_t state;
  logic [9:0]    div_cnt;
  logic          phase;
  logic          tick;
  logic [2:0]    bit_idx;
  logic [7:0]    shreg;
  logic          sda_s1;
  logic          sda_s2;
  logic          scl_q;
  logic          sda_drv;
  logic          sda_rel_q;

  // Commands queue so software can run ahead of the slow link
  lcd_fifo #(.WIDTH($bits(host_cmd_t)), .DEPTH(`FIFO_DEPTH)) cmd_q (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_cmd)
  );

  assign tick           = (div_cnt == `SCL_HALF_DIV);
  assign q_ready        = (state == MS_DONE) && tick;
  // Queued commands count as busy so gaps between bytes never look idle
  assign busy           = (state != MS_IDLE) || q_valid;
  assign link.scl       = scl_q;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe  = !sda_rel_q;

  // Data moves one cycle after the clock edge, so no false start or stop appears
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_rel_q <= 1'b1;
    end else begin
      sda_rel_q <= sda_drv;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 10'd1;
    end
  end

  // Each byte spends two ticks per bit: low half then high half
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= MS_IDLE;
      phase     <= 1'b0;
      scl_q     <= 1'b1;
      sda_drv   <= 1'b1;
      bit_idx   <= '0;
      shreg     <= '0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      nack_seen <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (tick) begin
        case (state)
          MS_IDLE: begin
            if (q_valid) begin
              state <= q_cmd.start ? MS_START : MS_BIT;
              shreg <= q_cmd.data;
              bit_idx <= 3'd7;
              phase <= 1'b0;
              if (q_cmd.start) begin
                // Clock low first so a repeated start can free the data line
                scl_q   <= 1'b0;
                sda_drv <= 1'b1;
              end
            end
          end
          MS_START: begin
            if (!phase) begin
              sda_drv <= 1'b1;
              scl_q   <= 1'b1;
              phase   <= 1'b1;
            end else begin
              sda_drv <= 1'b0;
              phase   <= 1'b0;
              state   <= MS_BIT;
            end
          end
          MS_BIT: begin
            if (!phase) begin
              scl_q   <= 1'b0;
              sda_drv <= q_cmd.rd ? 1'b1 : shreg[bit_idx];
              phase   <= 1'b1;
            end else begin
              scl_q <= 1'b1;
              phase <= 1'b0;
              shreg[bit_idx] <= q_cmd.rd ? sda_s2 : shreg[bit_idx];
              if (bit_idx == 3'd0) begin
                state <= MS_ACK;
              end else begin
                bit_idx <= bit_idx - 3'd1;
              end
            end
          end
          MS_ACK: begin
            if (!phase) begin
              scl_q   <= 1'b0;
              // Release on a withheld acknowledge
              sda_drv <= q_cmd.rd ? !q_cmd.ack_last : 1'b1;
              phase   <= 1'b1;
            end else begin
              scl_q <= 1'b1;
              phase <= 1'b0;
              if (q_cmd.rd) begin
                rd_valid <= 1'b1;
                rd_data  <= shreg;
              end else if (sda_s2) begin
                nack_seen <= 1'b1;
              end
              state <= q_cmd.stop ? MS_STOP1 : MS_DONE;
            end
          end
          MS_STOP1: begin
            scl_q   <= 1'b0;
            sda_drv <= 1'b0;
            state   <= MS_STOP2;
          end
          MS_STOP2: begin
            if (!phase) begin
              scl_q <= 1'b1;
              phase <= 1'b1;
            end else begin
              sda_drv <= 1'b1;
              phase   <= 1'b0;
              state   <= MS_DONE;
            end
          end
          MS_DONE: begin
            state <= MS_IDLE;
          end
          default: begin
            state <= MS_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== lcd_device_end.sv
`timescale 1ns/1ns
`include "lcd_link_params.svh"
module lcd_device_end (
  // Reset and link
  input  wire logic   arst_n,
  lcd_link_if.slave   link,
  // Display state
  output logic        display_on,
  output logic        cursor_on,
  output logic        blink_on,
  output logic [6:0]  ram_pointer,
  output logic [6:0]  display_shift,
  output logic        glyph_select,
  output logic [7:0]  read_holding_reg,
  output logic [7:0]  last_instr
);
  import lcd_link_pkg::*;
  // The link lines are the device's only clocks (scl, and sda edges for start and stop); no edges exist outside frames
  logic [7:0]   display_char_ram [`RAM_WORDS];
  logic [7:0]   user_glyph_ram [`GLYPH_WORDS];
  slave_state_t state;
  logic [7:0]   shreg;
  logic [2:0]   bit_cnt;
  logic         instr_data_select;
  logic         rw_sel;
  logic         continuation_flag;
  logic         start_seen;
  logic         start_clr;
  logic         start_tog;
  logic         start_ack;
  logic         stop_tog;
  logic         stop_ack;
  logic         do_ack;
  logic         out_bit;
  logic         drive_low;
  logic         rd_drive;
  logic [6:0]   next_read_ptr;
  entry_mode_t  entry_mode;
  logic         init_busy;
  logic [6:0]   init_idx;
  logic [7:0]   rx_byte;

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up);
    step_ptr = up ? p + 7'd1 : p - 7'd1;
  endfunction

  // Start and stop are sda edges while scl is high; toggles hand them to scl logic
  always_ff @(negedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      start_tog <= 1'b0;
    end else if (link.scl) begin
      start_tog <= !start_tog;
    end
  end

  always_ff @(posedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      stop_tog <= 1'b0;
    end else if (link.scl) begin
      stop_tog <= !stop_tog;
    end
  end

  assign start_seen = (start_tog != start_ack);
  assign rx_byte    = {shreg[6:0], link.sda};
  assign link.sda_s_out = 1'b0;
  assign link.sda_s_oe  = drive_low;
  // Read drive follows falling scl only, never the state change on rising scl
  assign drive_low      = do_ack || (rd_drive && !out_bit);
  assign next_read_ptr  = step_ptr(ram_pointer, 1'b1);

  // Bit reception on rising scl
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      state             <= SL_IDLE;
      shreg             <= '0;
      bit_cnt           <= '0;
      instr_data_select <= 1'b0;
      rw_sel            <= 1'b0;
      continuation_flag <= 1'b0;
      start_ack         <= 1'b0;
      stop_ack          <= 1'b0;
      display_on        <= 1'b0;
      cursor_on         <= 1'b0;
      blink_on          <= 1'b0;
      ram_pointer       <= '0;
      display_shift     <= '0;
      glyph_select      <= 1'b0;
      entry_mode        <= ENT_INC_NOSHIFT;
      read_holding_reg  <= '0;
      last_instr        <= '0;
      init_busy         <= 1'b1;
      init_idx          <= '0;
    end else begin
      if (init_busy) begin
        display_char_ram[init_idx] <= `BLANK_CHAR;
        init_idx  <= init_idx + 7'd1;
        init_busy <= (init_idx != 7'h7F);
      end
      if (stop_tog != stop_ack) begin
        stop_ack <= stop_tog;
      end
      if (start_seen) begin
        start_ack <= start_tog;
        state     <= SL_ADDR;
        shreg     <= {7'd0, link.sda};
        bit_cnt   <= 3'd1;
      end else begin
        case (state)
          SL_IDLE, SL_SKIP: begin
          end
          SL_ADDR, SL_CTRL, SL_WDATA: begin
            shreg   <= rx_byte;
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              bit_cnt <= '0;
            end
            if (state == SL_ADDR && bit_cnt == '0) begin
              state <= SL_SKIP;
            end
          end
          SL_RDATA: begin
            bit_cnt <= bit_cnt + 3'd1;
            shreg   <= {shreg[6:0], 1'b0};
            if (bit_cnt == 3'd7) begin
              state <= SL_RACK;
            end
          end
          SL_RACK: begin
            if (!link.sda) begin
              read_holding_reg <= glyph_select ? user_glyph_ram[next_read_ptr[5:0]]
                                               : display_char_ram[next_read_ptr];
              shreg            <= glyph_select ? user_glyph_ram[next_read_ptr[5:0]]
                                               : display_char_ram[next_read_ptr];
              ram_pointer      <= step_ptr(ram_pointer, 1'b1);
              state            <= SL_RDATA;
            end else begin
              state <= SL_SKIP;
            end
            bit_cnt <= '0;
          end
          default: begin
            state <= SL_IDLE;
          end
        endcase
      end
      // Acknowledge clock: bit_cnt wrapped and do_ack high
      if (!start_seen && do_ack) begin
        bit_cnt <= '0;
        case (state)
          SL_ADDR: begin
            if (shreg[0]) begin
              shreg <= read_holding_reg;
              state <= SL_RDATA;
            end else begin
              state <= SL_CTRL;
            end
          end
          SL_CTRL: begin
            continuation_flag <= shreg[`CTL_CONT_BIT];
            instr_data_select <= shreg[`CTL_RS_BIT];
            rw_sel            <= shreg[`CTL_RW_BIT];
            state             <= SL_WDATA;
          end
          SL_WDATA: begin
            state <= continuation_flag ? SL_CTRL : SL_WDATA;
            if (rw_sel) begin
              state <= SL_WDATA;
            end else if (instr_data_select) begin
              if (glyph_select) begin
                user_glyph_ram[ram_pointer[5:0]] <= shreg;
              end else begin
                display_char_ram[ram_pointer] <= shreg;
              end
              ram_pointer <= step_ptr(ram_pointer, entry_mode inside {ENT_INC_NOSHIFT, ENT_INC_SHIFT});
              if (entry_mode inside {ENT_INC_SHIFT, ENT_DEC_SHIFT}) begin
                // One offset for both lines keeps them shifting together
                display_shift <= step_ptr(display_shift, entry_mode == ENT_INC_SHIFT);
              end
            end else begin
              last_instr <= shreg;
              if (shreg == `CMD_CLEAR) begin
                ram_pointer   <= '0;
                display_shift <= '0;
                init_busy     <= 1'b1;
                init_idx      <= '0;
              end else if (shreg[7:1] == `CMD_HOME >> 1) begin
                ram_pointer   <= '0;
                display_shift <= '0;
              end else if (shreg[7:2] == 6'd1) begin
                entry_mode <= entry_mode_t'({!shreg[1], shreg[0]});
              end else if (shreg[7:3] == 5'd1) begin
                display_on <= shreg[2];
                cursor_on  <= shreg[1];
                blink_on   <= shreg[0];
              end else if (shreg[7:6] == 2'b01) begin
                glyph_select <= 1'b1;
                ram_pointer  <= {1'b0, shreg[5:0]};
              end else if (shreg[7]) begin
                glyph_select <= 1'b0;
                ram_pointer  <= shreg[6:0];
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Ack and output data change on falling scl
  always_ff @(negedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      do_ack   <= 1'b0;
      out_bit  <= 1'b1;
      rd_drive <= 1'b0;
    end else begin
      do_ack   <= 1'b0;
      out_bit  <= shreg[7];
      rd_drive <= (state == SL_RDATA);
      // Counter also reads zero right after the ack slot; do_ack tells the two apart
      if (bit_cnt == '0 && !start_seen && !do_ack) begin
        case (state)
          SL_ADDR: begin
            do_ack <= (shreg[7:1] == `SLAVE_ID);
          end
          SL_CTRL, SL_WDATA: begin
            do_ack <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (state == SL_RACK || state == SL_SKIP) begin
        out_bit <= 1'b1;
      end
      if (state == SL_ADDR && shreg[7:1] != `SLAVE_ID && bit_cnt == '0) begin
        do_ack <= 1'b0;
      end
    end
  end
endmodule

// ===== lcd_link_chk.sv
`timescale 1ns/1ns
`include "lcd_link_params.svh"
module lcd_link_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link wires
  input wire logic scl,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       rd_dir;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic       rise;
  logic       start_c;
  logic       ack;
  assign rise    = scl && !scl_q;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign ack     = rise && (bitcnt == 4'h8);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Framing rebuilt on the fast clock; scl edges are far apart, so one sample per phase is plenty
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      first  <= 1'b0;
      rd_dir <= 1'b0;
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        bitcnt <= 4'h0;
        first  <= 1'b1;
      end else if (rise) begin
        shreg <= {shreg[6:0], sda};
        if (bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          first  <= 1'b0;
          if (first) begin
            rd_dir <= shreg[0];
          end
        end else begin
          bitcnt <= bitcnt + 4'h1;
        end
      end
    end
  end
  sequence s_addr_hit;
    ack && first && (shreg[7:1] == `SLAVE_ID);
  endsequence
  sequence s_read_ack;
    ack && !first && rd_dir;
  endsequence
  property p_addr_ack;
    s_addr_hit |-> !sda && sda_s_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_ack_held;
    s_addr_hit |-> ##1 (!sda)[*8];
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("address ack released early");
  property p_addr_ignore;
    ack && first && (shreg[7:1] != `SLAVE_ID) |-> !sda_s_oe;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acknowledged");
  property p_wr_ack;
    ack && !first && !rd_dir |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
  property p_quiet;
    rise && (bitcnt != 4'h8) && !(rd_dir && !first) |-> !sda_s_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("slave drives during master bits");
  property p_rd_release;
    rise && rd_dir && !first && (bitcnt inside {[4'h1:4'h7]}) |-> !sda_m_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("master drives during read bits");
  property p_rd_ack_slot;
    s_read_ack |-> !sda_s_oe;
  endproperty
  a_rd_ack_slot: assert property (p_rd_ack_slot) else $error("slave holds line in master ack");
  property p_slave_hold;
    rise |-> ##1 ($stable(sda_s_oe))[*8];
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave changes data while clock high");
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
`include "lcd_link_params.svh"
module testbench;
  import lcd_link_pkg::*;
  logic       core_clk;
  logic       arst_n;
  logic       cmd_valid;
  logic       cmd_ready;
  host_cmd_t  cmd;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       nack_seen;
  logic       busy;
  logic       display_on;
  logic       cursor_on;
  logic       blink_on;
  logic [6:0] ram_pointer;
  logic [6:0] display_shift;
  logic       glyph_select;
  logic [7:0] read_holding_reg;
  logic [7:0] last_instr;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] rdq[$];
  int         num_errors;
  int         total_checks;
  int         seed;
  int         ptr;
  int         hold;
  int         ram[128];
  lcd_link_if link();
  lcd_host_end u_lcd_host_end (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data), .nack_seen(nack_seen), .busy(busy), .link(link));
  lcd_device_end u_lcd_device_end (.arst_n(arst_n), .link(link), .display_on(display_on), .cursor_on(cursor_on),
    .blink_on(blink_on), .ram_pointer(ram_pointer), .display_shift(display_shift), .glyph_select(glyph_select),
    .read_holding_reg(read_holding_reg), .last_instr(last_instr));
  lcd_link_chk u_lcd_link_chk (.core_clk(core_clk), .arst_n(arst_n), .scl(link.scl), .sda_m_out(link.sda_m_out),
    .sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out), .sda_s_oe(link.sda_s_oe), .sda(link.sda));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      rdq.push_back(rd_data);
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One byte command; held until the fifo takes it
  task send(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd = {s, p, r, a, d};
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      $display("mismatch at %0t: command never taken", $time);
      end_of_test();
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    repeat (4) @(negedge core_clk);
    while (busy !== 1'b0 && n < 50000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 50000) begin
      num_errors++;
      $display("mismatch at %0t: link never went idle", $time);
      end_of_test();
    end
    repeat (4) @(negedge core_clk);
  endtask
  // Reference model of pointer and display memory
  task mwrite(input logic [7:0] d);
    ram[ptr] = d;
    ptr = (ptr + 1) % 128;
  endtask
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    seed = 34;
    num_errors = 0;
    total_checks = 0;
    ptr = 0;
    hold = 0;
    for (int i = 0; i < 128; i++) begin
      ram[i] = 32'h20;
    end
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    c0 = 8'($random(seed));
    c1 = 8'($random(seed));
    // Foreign id: no answer, nothing changes
    send(1'b1, 1'b1, 1'b0, 1'b0, {`SLAVE_ID ^ 7'h01, 1'b0});
    wait_idle();
    check({7'h00, nack_seen}, 8'h01, "foreign id nack");
    check({1'b0, ram_pointer}, 8'h00, "pointer after foreign id");
    // Two characters after a data control byte
    send(1'b1, 1'b0, 1'b0, 1'b0, {`SLAVE_ID, 1'b0});
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h40);
    send(1'b0, 1'b0, 1'b0, 1'b0, c0);
    mwrite(c0);
    send(1'b0, 1'b1, 1'b0, 1'b0, c1);
    mwrite(c1);
    wait_idle();
    check({1'b0, ram_pointer}, 8'(ptr), "pointer after writes");
    // Single-byte control pairs, home, read setup, then a repeated start to read
    send(1'b1, 1'b0, 1'b0, 1'b0, {`SLAVE_ID, 1'b0});
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h0E);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    send(1'b0, 1'b0, 1'b0, 1'b0, `CMD_HOME);
    ptr = 0;
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h60);
    send(1'b1, 1'b0, 1'b0, 1'b0, {`SLAVE_ID, 1'b1});
    send(1'b0, 1'b0, 1'b1, 1'b1, 8'hFF);
    ptr = (ptr + 1) % 128;
    hold = ram[ptr];
    send(1'b0, 1'b1, 1'b1, 1'b0, 8'hFF);
    wait_idle();
    // First byte is stale holding content, so only its arrival is checked
    check(8'(rdq.size()), 8'h02, "read byte count");
    if (rdq.size() == 2) begin
      check(rdq[1], 8'(hold), "byte after master ack");
    end
    check(read_holding_reg, 8'(hold), "holding after no ack");
    check({1'b0, ram_pointer}, 8'(ptr), "pointer after no ack");
    check({5'h00, display_on, cursor_on, blink_on}, 8'h06, "display and cursor on");
    check({1'b0, display_shift}, 8'h00, "shift after home");
    check(last_instr, `CMD_HOME, "last instruction");
    // Second line start, then a write in shift mode
    send(1'b1, 1'b0, 1'b0, 1'b0, {`SLAVE_ID, 1'b0});
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    send(1'b0, 1'b0, 1'b0, 1'b0, {1'b1, `LINE2_ADDR});
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h07);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h40);
    send(1'b0, 1'b1, 1'b0, 1'b0, c0);
    ptr = `LINE2_ADDR;
    mwrite(c0);
    wait_idle();
    check({glyph_select, ram_pointer}, 8'(ptr), "pointer on second line");
    check({1'b0, display_shift}, 8'h01, "shift after write in shift mode");
    check(last_instr, 8'h07, "entry mode instruction");
    end_of_test();
  end
endmodule
